// >>> debug_wire_link.sv
// target side of the single-wire background debug link
`timescale 1ns/10ps
module debug_wire_link (
	input  wire logic                     i_clock,
	input  wire logic                     i_rst_b,
	input  wire logic                     i_alt_tick,
	input  wire logic                     i_pin,
	output logic                          o_pin_out,
	output logic                          o_pin_oe,
	input  wire logic                     i_force_background,
	input  wire logic                     i_halt,
	input  wire logic                     i_cmd_done,
	input  wire logic                     i_tx_valid,
	input  wire logic [7:0]               i_tx_data,
	output logic                          o_tx_ready,
	output logic                          o_word_valid,
	input  wire logic                     i_word_ready,
	output debug_link_pkg::rx_word_t      o_word,
	output logic                          o_background,
	output logic                          o_wake,
	output logic                          o_go,
	output logic                          o_step,
	output logic                          o_osc_keep,
	output logic                          o_watchdog_off,
	output logic                          o_clock_select
);
	import debug_link_pkg::*;

	link_state_t s;
	link_state_t next_s;
	logic        tick;
	logic        fall;
	logic        sample;
	logic        bitv;
	logic [7:0]  byte_in;
	logic        push_ready;
	logic [WORD_W-1:0] fifo_out;

	// =========================================================
	// debug clock rate
	// alternate source arrives as a one-cycle enable from a divider
	assign tick = s.ctrl[CTRL_CLKSEL_BIT] ? i_alt_tick : 1'b1;

	// =========================================================
	// link state machine
	always_comb begin
		next_s = s;
		next_s.wake = 1'b0;
		next_s.go = 1'b0;
		next_s.step = 1'b0;
		next_s.pin_meta = i_pin;
		next_s.pin_sync = s.pin_meta;
		next_s.pin_prev = s.pin_sync;
		fall = s.pin_prev && !s.pin_sync;
		sample = 1'b0;
		bitv = s.pin_sync;
		byte_in = {s.sh[6:0], bitv};

		if (s.push_v && push_ready) begin
			next_s.push_v = 1'b0;
		end

		// pod-less pin reads high here, so the strap picks normal mode
		if (s.strap != 2'h0) begin
			next_s.strap = s.strap - 2'h1;
			if (s.strap == STRAP_TAKE) begin
				next_s.bg = !s.pin_sync;
			end
		end
		if (i_force_background) begin
			next_s.strap = STRAP_WAIT;
		end
		if (i_halt) begin
			next_s.bg = 1'b1;
		end

		if (fall) begin
			next_s.idle = '0;
		end else if (tick && s.idle != TIMEOUT) begin
			next_s.idle = s.idle + 10'h001;
		end

		unique case (s.st)
			L_IDLE: begin
				next_s.drv_oe = 1'b0;
				// only a host edge starts a bit; a pending word holds it off
				if (fall && !s.push_v) begin
					next_s.cnt = '0;
					if (s.ph == PH_TX) begin
						next_s.st = L_TX;
						next_s.drv_oe = !s.tx[7];
						next_s.drv_val = 1'b0;
					end else begin
						next_s.st = L_RX;
					end
				end else if (i_tx_valid) begin
					next_s.tx = i_tx_data;
					next_s.ph = PH_TX;
					next_s.nbit = '0;
				end else if (i_cmd_done) begin
					next_s.ph = PH_CMD;
					next_s.nbit = '0;
				end
			end
			L_RX: begin
				next_s.drv_oe = 1'b0;
				if (tick) begin
					next_s.cnt = s.cnt + CNT_STEP;
					if (s.cnt == RX_SAMPLE) begin
						sample = 1'b1;
					end else if (s.cnt > RX_SAMPLE && s.pin_sync) begin
						next_s.st = L_IDLE;
					end else if (!s.pin_sync && s.cnt == SYNC_MIN_LOW) begin
						next_s.st = L_SYNC_HIGH;
						next_s.ph = PH_CMD;
						next_s.nbit = '0;
					end
				end
			end
			L_TX: begin
				if (tick) begin
					next_s.cnt = s.cnt + CNT_STEP;
					if (s.drv_oe && s.drv_val) begin
						next_s.drv_oe = 1'b0;
						next_s.tx = {s.tx[6:0], 1'b0};
						next_s.nbit = s.nbit + 3'h1;
						next_s.st = L_WAIT_HIGH;
						if (s.nbit == LAST_BIT) begin
							next_s.ph = (s.cmd == CMD_RD_STATUS) ? PH_CMD : PH_RX;
						end
					end else if (s.tx[7] && s.cnt == TX_ONE_PULSE - CNT_STEP) begin
						next_s.drv_oe = 1'b1;
						next_s.drv_val = 1'b1;
					end else if (!s.tx[7] && s.cnt == TX_ZERO_LOW - CNT_STEP) begin
						next_s.drv_val = 1'b1;
					end
				end
			end
			L_WAIT_HIGH: begin
				if (s.pin_sync) begin
					next_s.st = L_IDLE;
				end
			end
			L_SYNC_HIGH: begin
				if (s.pin_sync) begin
					next_s.cnt = '0;
					next_s.st = L_SYNC_WAIT;
				end
			end
			L_SYNC_WAIT: begin
				// lets the host finish its own speedup pulse
				if (tick) begin
					next_s.cnt = s.cnt + CNT_STEP;
					if (s.cnt == SYNC_DELAY - CNT_STEP) begin
						next_s.cnt = '0;
						next_s.drv_oe = 1'b1;
						next_s.drv_val = 1'b0;
						next_s.st = L_SYNC_LOW;
					end
				end
			end
			L_SYNC_LOW: begin
				if (tick) begin
					next_s.cnt = s.cnt + CNT_STEP;
					if (s.cnt == SYNC_LOW - CNT_STEP) begin
						next_s.drv_val = 1'b1;
						next_s.st = L_SYNC_PULSE;
					end
				end
			end
			L_SYNC_PULSE: begin
				if (tick) begin
					next_s.drv_oe = 1'b0;
					next_s.st = L_WAIT_HIGH;
				end
			end
		endcase

		// =========================================================
		// byte assembly and command sorting
		if (sample) begin
			next_s.sh = byte_in;
			next_s.nbit = s.nbit + 3'h1;
			if (s.nbit == LAST_BIT) begin
				unique case (s.ph)
					PH_CMD: begin
						next_s.cmd = byte_in;
						next_s.nbit = '0;
						if (byte_in == CMD_BACKGROUND) begin
							next_s.wake = s.ctrl[CTRL_EN_BIT];
							next_s.bg = s.bg | s.ctrl[CTRL_EN_BIT];
						end else if (byte_in == CMD_WR_CONTROL) begin
							next_s.ph = PH_CTRL;
						end else if (byte_in == CMD_RD_STATUS) begin
							next_s.tx = s.ctrl;
							next_s.tx[CTRL_BG_BIT] = s.bg;
							next_s.ph = PH_TX;
						end else if (!byte_in[NONINTR_BIT] && !s.bg) begin
							next_s.ph = PH_SKIP;
						end else begin
							next_s.push = '{first: 1'b1, cmd: byte_in, data: 8'h00};
							next_s.push_v = 1'b1;
							next_s.ph = PH_RX;
							if (byte_in == CMD_GO || byte_in == CMD_TAGGO) begin
								next_s.go = 1'b1;
								next_s.bg = 1'b0;
							end else if (byte_in == CMD_STEP) begin
								next_s.step = 1'b1;
								next_s.bg = 1'b0;
							end
						end
					end
					PH_CTRL: begin
						next_s.ctrl = byte_in;
						next_s.ph = PH_CMD;
					end
					PH_RX: begin
						next_s.push = '{first: 1'b0, cmd: s.cmd, data: byte_in};
						next_s.push_v = 1'b1;
					end
					PH_TX, PH_SKIP: begin
					end
				endcase
			end
		end

		// idle host drops the command; memory and mode are left alone
		if (tick && s.idle == TIMEOUT - 10'h001) begin
			next_s.ph = PH_CMD;
			next_s.nbit = '0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= '{st: L_IDLE, ph: PH_CMD, cnt: '0, idle: '0, pin_meta: 1'b1,
				pin_sync: 1'b1, pin_prev: 1'b1, nbit: '0, sh: '0, tx: '0, cmd: '0,
				ctrl: CTRL_RESET, bg: 1'b0, strap: STRAP_WAIT, drv_oe: 1'b0,
				drv_val: 1'b0, push: '0, push_v: 1'b0, wake: 1'b0, go: 1'b0,
				step: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// =========================================================
	// word buffer toward the debug core
	debug_word_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clock     (i_clock),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (s.push_v),
		.o_in_ready  (push_ready),
		.i_in_data   (s.push),
		.o_out_valid (o_word_valid),
		.i_out_ready (i_word_ready),
		.o_out_data  (fifo_out)
	);

	assign o_word = rx_word_t'(fifo_out);
	assign o_pin_out = s.drv_val;
	assign o_pin_oe = s.drv_oe;
	assign o_tx_ready = (s.st == L_IDLE) && !fall;
	assign o_background = s.bg;
	assign o_wake = s.wake;
	assign o_go = s.go;
	assign o_step = s.step;
	assign o_osc_keep = s.ctrl[CTRL_EN_BIT];
	assign o_watchdog_off = s.bg;
	assign o_clock_select = s.ctrl[CTRL_CLKSEL_BIT];

	// =========================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	sequence s_hold_low;
		(o_pin_oe && !o_pin_out)[*8];
	endsequence

	sequence s_rx_start;
		$rose(s.st == L_RX) && !o_clock_select;
	endsequence

	chk_rx_no_drive: assert property (s.st == L_RX |-> !o_pin_oe)
		else $error("pin driven during host bit");
	chk_one_pulse: assert property (tick && s.st == L_TX && s.tx[7]
		&& s.cnt == TX_ONE_PULSE - CNT_STEP && !s.drv_oe |=> o_pin_oe && o_pin_out)
		else $error("one speedup pulse missing");
	chk_zero_low: assert property (s.st == L_TX && !s.tx[7] && s.cnt < TX_ZERO_LOW
		|-> o_pin_oe && !o_pin_out)
		else $error("zero bit not held low");
	chk_pulse_release: assert property (o_pin_oe && o_pin_out && tick |=> !o_pin_oe)
		else $error("pin not released after pulse");
	chk_sync_reply: assert property ($rose(s.st == L_SYNC_LOW) && !o_clock_select
		|-> s_hold_low)
		else $error("sync reply low too short");
	chk_sample_ten: assert property (s_rx_start |-> ##10 sample)
		else $error("bit not sampled at ten cycles");
	chk_timeout_abort: assert property (tick && s.idle == TIMEOUT - 10'h001
		&& s.st == L_IDLE |=> s.ph == PH_CMD && s.nbit == 3'h0)
		else $error("timeout did not abort command");
	chk_active_gate: assert property (sample && s.nbit == LAST_BIT && s.ph == PH_CMD
		&& !s.bg && !byte_in[NONINTR_BIT] |=> !s.push_v && !o_go && !o_step)
		else $error("active command run outside background");
	chk_strap_entry: assert property (s.strap == STRAP_TAKE && !s.pin_sync && !i_halt
		|=> o_background)
		else $error("low strap did not enter background");
	chk_clock_gate: assert property (o_clock_select && !i_alt_tick && s.st == L_RX
		|=> $stable(s.cnt))
		else $error("counter moved without debug clock");
endmodule

// >>> debug_link_pkg.sv
// constants and types shared by the single-wire debug link
package debug_link_pkg;

	// counts in debug-clock cycles; the strap delay counts bus clock cycles
	localparam logic [7:0] RX_SAMPLE    = 8'h0a;
	localparam logic [7:0] TX_ONE_PULSE = 8'h07;
	localparam logic [7:0] TX_ZERO_LOW  = 8'h0d;
	localparam logic [7:0] SYNC_MIN_LOW = 8'h80;
	localparam logic [7:0] SYNC_DELAY   = 8'h10;
	localparam logic [7:0] SYNC_LOW     = 8'h80;
	localparam logic [7:0] CNT_STEP     = 8'h01;
	localparam logic [9:0] TIMEOUT      = 10'h200;
	localparam logic [1:0] STRAP_WAIT   = 2'h3;
	localparam logic [1:0] STRAP_TAKE   = 2'h1;
	localparam logic [2:0] LAST_BIT     = 3'h7;

	// command codes handled inside the link
	localparam logic [7:0] CMD_BACKGROUND = 8'h90;
	localparam logic [7:0] CMD_WR_CONTROL = 8'hc4;
	localparam logic [7:0] CMD_RD_STATUS  = 8'he4;
	localparam logic [7:0] CMD_GO         = 8'h08;
	localparam logic [7:0] CMD_TAGGO      = 8'h18;
	localparam logic [7:0] CMD_STEP       = 8'h10;
	localparam int         NONINTR_BIT    = 7;

	// debug_status_control_reg layout
	localparam int         CTRL_EN_BIT     = 7;
	localparam int         CTRL_BG_BIT     = 6;
	localparam int         CTRL_CLKSEL_BIT = 2;
	localparam logic [7:0] CTRL_RESET      = 8'h00;

	localparam int FIFO_DEPTH = 32;

	typedef enum logic [2:0] {
		L_IDLE, L_RX, L_TX, L_WAIT_HIGH, L_SYNC_HIGH, L_SYNC_WAIT, L_SYNC_LOW, L_SYNC_PULSE
	} link_st_t;

	typedef enum logic [2:0] {PH_CMD, PH_RX, PH_TX, PH_CTRL, PH_SKIP} phase_t;

	typedef struct packed {
		logic       first;
		logic [7:0] cmd;
		logic [7:0] data;
	} rx_word_t;

	localparam int WORD_W = $bits(rx_word_t);

	typedef struct packed {
		link_st_t   st;
		phase_t     ph;
		logic [7:0] cnt;
		logic [9:0] idle;
		logic       pin_meta;
		logic       pin_sync;
		logic       pin_prev;
		logic [2:0] nbit;
		logic [7:0] sh;
		logic [7:0] tx;
		logic [7:0] cmd;
		logic [7:0] ctrl;
		logic       bg;
		logic [1:0] strap;
		logic       drv_oe;
		logic       drv_val;
		rx_word_t   push;
		logic       push_v;
		logic       wake;
		logic       go;
		logic       step;
	} link_state_t;

endpackage

// >>> debug_word_fifo.sv
// word fifo between the serial link and the debug core
`timescale 1ns/10ps
module debug_word_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 32
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_b,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic [WIDTH-1:0]            out;
		logic                        out_v;
	} fifo_st_t;

	fifo_st_t s;
	fifo_st_t next_s;
	logic     push;
	logic     pop;

	// read data leave through a register; one extra word sits in it
	always_comb begin
		next_s = s;
		push = i_in_valid && (s.cnt != (AW+1)'(DEPTH));
		pop = (s.cnt != '0) && (!s.out_v || i_out_ready);
		if (push) begin
			next_s.mem[s.wp] = i_in_data;
			next_s.wp = s.wp + 1'b1;
		end
		if (pop) begin
			next_s.out = s.mem[s.rp];
			next_s.rp = s.rp + 1'b1;
			next_s.out_v = 1'b1;
		end else if (i_out_ready) begin
			next_s.out_v = 1'b0;
		end
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_in_ready = (s.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = s.out_v;
	assign o_out_data = s.out;
endmodule

// >>> debug_pod_model.sv
// host-side pod model for the single debug wire
`timescale 1ns/10ps
module debug_pod_model (
	input  wire logic       i_clock,
	input  wire logic       i_pin,
	input  wire logic       i_dev_oe,
	output logic            o_pod_oe,
	output logic            o_pod_out,
	output logic      [7:0] o_clash
);
	// bus cycles per debug-clock tick; raised while the alternate clock runs
	int slow = 1;
	// ==============================
	// drive conflict watch
	initial begin
		o_pod_oe = 1'b0;
		o_pod_out = 1'b1;
		o_clash = 8'h00;
	end
	// both may pull low together; opposite levels driven at once is a fight
	always @(posedge i_clock) begin
		if (o_pod_oe && i_dev_oe && o_pod_out !== i_pin) begin
			o_clash <= o_clash + 8'h01;
		end
	end
	// ==============================
	// pin tasks
	task automatic hold(input logic low);
		@(posedge i_clock);
		o_pod_oe <= low;
		o_pod_out <= 1'b0;
	endtask
	// 20-tick bits leave margin around the sample point
	task automatic send_bit(input logic b);
		@(posedge i_clock);
		o_pod_oe <= 1'b1;
		o_pod_out <= 1'b0;
		repeat (b ? 4 : 16 * slow) @(posedge i_clock);
		o_pod_out <= 1'b1;
		repeat (b ? 20 * slow - 5 : 4 * slow - 1) @(posedge i_clock);
	endtask
	task automatic send_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			send_bit(v[i]);
		end
		@(posedge i_clock);
		o_pod_oe <= 1'b0;
	endtask
	task automatic recv_byte(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			@(posedge i_clock);
			o_pod_oe <= 1'b1;
			o_pod_out <= 1'b0;
			repeat (2 * slow) @(posedge i_clock);
			o_pod_oe <= 1'b0;
			repeat (8 * slow) @(posedge i_clock);
			#1 v[i] = i_pin;
			repeat (10 * slow - 1) @(posedge i_clock);
		end
	endtask
	task automatic sync(output int n);
		@(posedge i_clock);
		o_pod_oe <= 1'b1;
		o_pod_out <= 1'b0;
		repeat (140) @(posedge i_clock);
		o_pod_out <= 1'b1;
		@(posedge i_clock);
		o_pod_oe <= 1'b0;
		n = 0;
		for (int k = 0; k < 400; k++) begin
			@(posedge i_clock);
			#1 n += int'(i_pin === 1'b0);
		end
	endtask
endmodule

// >>> test_debug_wire_link.sv
// self-checking bench for the single-wire debug link
`timescale 1ns/10ps
module test_debug_wire_link;
	import debug_link_pkg::*;
	logic       clock;
	logic       rst_b;
	logic       alt_tick;
	logic       force_bg;
	logic       halt;
	logic       cmd_done;
	logic       tx_valid;
	logic [7:0] tx_data;
	logic       word_ready;
	wire        pin;
	logic       dev_out, dev_oe, pod_oe, pod_out, tx_ready, word_valid;
	logic       background, wake, go, step, osc_keep, wd_off, clk_sel;
	logic [7:0] clash;
	logic [7:0] rd;
	rx_word_t   word;
	rx_word_t   words[$];
	int         n_errors   = 0;
	int         checked    = 0;
	int         n_go       = 0;
	int         n_wake     = 0;
	int         n_step     = 0;
	int         n;
	// ==============================
	// clock, wire and monitors
	always #5 clock = ~clock;
	always @(posedge clock) alt_tick <= ~alt_tick;
	// released wire floats high through the pull-up
	assign pin = dev_oe ? dev_out : (pod_oe ? pod_out : 1'b1);
	always @(posedge clock) begin
		if (word_valid === 1'b1 && word_ready === 1'b1) begin
			words.push_back(word);
		end
		n_go <= n_go + int'(go === 1'b1);
		n_wake <= n_wake + int'(wake === 1'b1);
		n_step <= n_step + int'(step === 1'b1);
	end
	debug_wire_link DUT (.i_clock(clock), .i_rst_b(rst_b), .i_alt_tick(alt_tick),
		.i_pin(pin), .o_pin_out(dev_out), .o_pin_oe(dev_oe),
		.i_force_background(force_bg), .i_halt(halt), .i_cmd_done(cmd_done),
		.i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
		.o_word_valid(word_valid), .i_word_ready(word_ready), .o_word(word),
		.o_background(background), .o_wake(wake), .o_go(go), .o_step(step),
		.o_osc_keep(osc_keep), .o_watchdog_off(wd_off), .o_clock_select(clk_sel));
	debug_pod_model pod (.i_clock(clock), .i_pin(pin), .i_dev_oe(dev_oe),
		.o_pod_oe(pod_oe), .o_pod_out(pod_out), .o_clash(clash));
	// ==============================
	// shared tasks
	task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checked %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic rst(input logic low);
		@(posedge clock);
		rst_b <= 1'b0;
		pod.hold(low);
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		repeat (6) @(posedge clock);
		pod.hold(1'b0);
		// a strap low may look like a partial bit until it times out
		repeat (low ? 600 : 4) @(posedge clock);
	endtask
	task automatic done;
		@(posedge clock);
		cmd_done <= 1'b1;
		@(posedge clock);
		cmd_done <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task automatic rd_status(input logic [7:0] ctrl, input logic bg);
		logic [7:0] v;
		pod.send_byte(CMD_RD_STATUS);
		pod.recv_byte(v);
		check("status", v, ctrl | ({7'h00, bg} << CTRL_BG_BIT));
	endtask
	task automatic wr_ctrl(input logic [7:0] v);
		pod.send_byte(CMD_WR_CONTROL);
		pod.send_byte(v);
		repeat (4) @(posedge clock);
	endtask
	// ==============================
	// scenarios
	task automatic t_strap(input logic low);
		rst(low);
		check("background", background, low);
		check("watchdog_off", wd_off, low);
		check("osc_keep", osc_keep, 1'b0);
		rd_status(CTRL_RESET, low);
		$display("strap test done");
	endtask
	task automatic t_nonintr;
		word_ready <= 1'b0;
		pod.send_byte(8'hc0);
		pod.send_byte(8'ha5);
		pod.send_byte(8'h5a);
		check("stalled valid", word_valid, 1'b1);
		word_ready <= 1'b1;
		repeat (4) @(posedge clock);
		check("word count", words.size(), 3);
		check("cmd word", words[0], {1'b1, 8'hc0, 8'h00});
		check("data word", words[1], {1'b0, 8'hc0, 8'ha5});
		check("data word", words[2], {1'b0, 8'hc0, 8'h5a});
		done();
		pod.send_byte(8'he0);
		tx_data <= 8'h3c;
		tx_valid <= 1'b1;
		for (int k = 0; k < 50; k++) begin
			@(negedge clock);
			if (tx_ready === 1'b1) break;
		end
		check("tx ready", tx_ready, 1'b1);
		@(posedge clock);
		tx_valid <= 1'b0;
		pod.recv_byte(rd);
		check("read byte", rd, 8'h3c);
		done();
		$display("non-intrusive test done");
	endtask
	task automatic t_active;
		logic [7:0] codes[3];
		codes = '{CMD_STEP, CMD_GO, CMD_TAGGO};
		pod.send_byte(CMD_GO);
		repeat (600) @(posedge clock);
		check("go refused", n_go, 0);
		check("background", background, 1'b0);
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			halt <= 1'b1;
			@(posedge clock);
			halt <= 1'b0;
			repeat (2) @(posedge clock);
			check("halted", background, 1'b1);
			check("watchdog_off", wd_off, 1'b1);
			pod.send_byte(codes[i]);
			done();
		end
		check("step", n_step, 1);
		check("go", n_go, 2);
		check("running", background, 1'b0);
		$display("active test done");
	endtask
	task automatic t_control;
		pod.send_byte(CMD_BACKGROUND);
		repeat (600) @(posedge clock);
		check("wake disabled", n_wake, 0);
		wr_ctrl(8'h80);
		check("osc_keep", osc_keep, 1'b1);
		pod.send_byte(CMD_BACKGROUND);
		repeat (4) @(posedge clock);
		check("wake", n_wake, 1);
		check("background", background, 1'b1);
		done();
		rd_status(8'h80, 1'b1);
		pod.send_byte(CMD_GO);
		done();
		$display("control test done");
	endtask
	task automatic t_force_timeout;
		fork
			pod.hold(1'b1);
			begin
				@(posedge clock);
				force_bg <= 1'b1;
			end
		join
		@(posedge clock);
		force_bg <= 1'b0;
		repeat (5) @(posedge clock);
		pod.hold(1'b0);
		repeat (600) @(posedge clock);
		check("forced", background, 1'b1);
		for (int i = 0; i < 4; i++) begin
			pod.send_bit(1'b0);
		end
		pod.hold(1'b0);
		repeat (600) @(posedge clock);
		rd_status(8'h80, 1'b1);
		$display("force and timeout test done");
	endtask
	task automatic t_sync;
		pod.sync(n);
		check("sync low", n, SYNC_LOW);
		rd_status(8'h80, 1'b1);
		$display("sync test done");
	endtask
	task automatic t_clksel;
		wr_ctrl(8'h84);
		check("clock_select", clk_sel, 1'b1);
		// alternate tick runs at half rate, so the pod stretches its bits
		pod.slow = 2;
		rd_status(8'h84, 1'b1);
		pod.slow = 1;
		check("pin clash", clash, 8'h00);
		$display("clock select test done");
	endtask
	// ==============================
	// sequence and watchdog
	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		alt_tick = 1'b0;
		force_bg = 1'b0;
		halt = 1'b0;
		cmd_done = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		word_ready = 1'b1;
		t_strap(1'b0);
		t_nonintr;
		t_active;
		t_control;
		t_force_timeout;
		t_sync;
		t_strap(1'b1);
		t_clksel;
		summarize;
	end
	// about 9k cycles expected; far past that means a hang
	initial begin
		#600_000;
		n_errors++;
		$display("BAD watchdog expected finish seen hang");
		summarize;
	end
endmodule
